//--- include/uls_pkg.sv
// Functional notes
// - single-byte mode: holding-empty sets when the character moves to the shifter
// - FIFO mode: holding-empty set while transmit FIFO empty; reads 1 after reset
// - single-byte mode: holding-empty clears on the CPU write of the holding register
// - FIFO mode: holding-empty clears once one or more bytes are written
// - break indicator is status bit 4, reset value 0
// - break set when input stays low longer than one whole frame
// - break cleared by status read or by loading the next valid character
// - FIFO mode: break stored with its character, shown when it reaches the head
// - a break loads exactly one all-zero character, however long it lasts
// - after a break, reception resumes only after a high level then a start bit
// - framing error indicator is status bit 3, reset value 0
// - framing error set when the first stop bit samples low
// - break or framing error at the head raises the line status interrupt if enabled
// - holding-empty is status bit 5 and interrupts when set and enabled
package uls_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_STAT = 8'h00;
    localparam logic [7:0] OFS_CTRL = 8'h04;
    localparam logic [7:0] OFS_TX   = 8'h08;
    localparam logic [7:0] OFS_RX   = 8'h0C;
    localparam logic [7:0] OFS_IST  = 8'h10;
    localparam logic [7:0] OFS_IMSK = 8'h14;

    // field positions
    localparam int STAT_FRM_BIT  = 3;
    localparam int STAT_BRK_BIT  = 4;
    localparam int STAT_HOLD_BIT = 5;
    localparam int CTRL_FIFO     = 0;
    localparam int IRQ_RLS       = 0;
    localparam int IRQ_HOLD      = 1;

    // reset values and frame shape
    localparam logic [7:0] STAT_RESET = 8'h20;
    localparam logic       CTRL_RESET = 1'b0;
    localparam int         FRAME_BITS = 10;

    // receiver states
    typedef enum logic [2:0] {
        RX_IDLE  = 3'b000,
        RX_START = 3'b001,
        RX_DATA  = 3'b010,
        RX_STOP  = 3'b011,
        RX_HOLD  = 3'b100,
        RX_MARK  = 3'b101
    } uls_rx_state_type;

    // one receive FIFO entry: error bits plus data
    typedef struct packed {
        logic       brk;
        logic       frm;
        logic [7:0] data;
    } uls_rx_entry_type;

    // classic wishbone request and response
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } uls_wb_req_type;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } uls_wb_rsp_type;

endpackage

//--- rtl/uls_top.sv
`timescale 1ns/1ps
module uls_top #(
    parameter int RX_DEPTH     = 16,
    parameter int TX_DEPTH     = 16,
    parameter int CLKS_PER_BIT = 16
) (
    // clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // wishbone slave
    input  wire uls_pkg::uls_wb_req_type wb_req_i,
    output uls_pkg::uls_wb_rsp_type      wb_rsp_o,
    // serial line
    input  wire logic                    serial_input_i,
    // transmit shift register side
    input  wire logic                    tx_take_i,
    output logic                         tx_valid_o,
    output logic [7:0]                   tx_data_o,
    // interrupt
    output logic                         irq_o
);

    localparam int RAW = $clog2(RX_DEPTH);
    localparam int TAW = $clog2(TX_DEPTH);
    localparam logic [RAW:0] RX_LIM     = (RAW+1)'(RX_DEPTH);
    localparam logic [TAW:0] TX_LIM     = (TAW+1)'(TX_DEPTH);
    localparam logic [15:0]  BIT_END    = 16'(CLKS_PER_BIT - 1);
    localparam logic [15:0]  MID_END    = 16'(CLKS_PER_BIT / 2 - 1);
    localparam logic [15:0]  FRAME_CLKS = 16'(CLKS_PER_BIT * uls_pkg::FRAME_BITS);

    // parameter sanity
    if (RX_DEPTH < 2 || (1 << RAW) != RX_DEPTH || TX_DEPTH < 2 || (1 << TAW) != TX_DEPTH ||
        CLKS_PER_BIT < 4 || CLKS_PER_BIT > 4096) begin : g_bad
        $error("uls_top: depths must be powers of two, bit time 4..4096 clocks");
    end

    typedef struct packed {
        uls_pkg::uls_rx_state_type                   rx_state;
        logic                                        line_meta;
        logic                                        line_sync;
        logic [15:0]                                 bit_cnt;
        logic [2:0]                                  bit_idx;
        logic [7:0]                                  shift;
        logic [15:0]                                 low_cnt;
        uls_pkg::uls_rx_entry_type [RX_DEPTH-1:0]    rx_mem;
        logic [RAW-1:0]                              rx_rd;
        logic [RAW-1:0]                              rx_wr;
        logic [RAW:0]                                rx_cnt;
        logic [TX_DEPTH-1:0][7:0]                    tx_mem;
        logic [TAW-1:0]                              tx_rd;
        logic [TAW-1:0]                              tx_wr;
        logic [TAW:0]                                tx_cnt;
        logic                                        hold_empty;
        logic                                        brk;
        logic                                        frm;
        logic                                        fifo_en;
        logic [1:0]                                  irq_st;
        logic [1:0]                                  irq_mask;
        logic                                        ack;
        logic [31:0]                                 dat;
    } uls_state_type;

    uls_state_type             st_reg;
    uls_state_type             st_next;
    logic                      s;
    logic                      acc;
    logic                      wr;
    logic                      rd;
    logic [7:0]                stat;
    logic                      tx_push;
    logic                      tx_take;
    logic                      tx_ok;
    logic                      rx_pop;
    logic                      rx_push;
    logic                      rx_ok;
    logic                      head_load;
    logic                      stat_rd;
    logic [RAW:0]              rx_lim;
    logic [TAW:0]              tx_lim;
    uls_pkg::uls_rx_entry_type push_ent;
    uls_pkg::uls_rx_entry_type head_ent;
    logic [1:0]                irq_ev;

    // next-state logic
    always_comb begin
        st_next  = st_reg;
        s        = st_reg.line_sync;
        acc      = wb_req_i.cyc && wb_req_i.stb && !st_reg.ack;
        wr       = acc && wb_req_i.we;
        rd       = acc && !wb_req_i.we;
        rx_push  = 1'b0;
        push_ent = '0;
        irq_ev   = 2'h0;
        stat     = 8'h00;
        stat[uls_pkg::STAT_HOLD_BIT] = st_reg.hold_empty;
        stat[uls_pkg::STAT_BRK_BIT]  = st_reg.brk;
        stat[uls_pkg::STAT_FRM_BIT]  = st_reg.frm;
        stat_rd = rd && wb_req_i.adr == uls_pkg::OFS_STAT;
        tx_push = wr && wb_req_i.adr == uls_pkg::OFS_TX && wb_req_i.sel[0];
        rx_pop  = rd && wb_req_i.adr == uls_pkg::OFS_RX && st_reg.rx_cnt != '0;

        // bus answer, one cycle after the request is seen
        st_next.ack = acc;
        st_next.dat = 32'h0000_0000;
        if (stat_rd) begin
            st_next.dat = {24'h00_0000, stat};
        end else if (rd && wb_req_i.adr == uls_pkg::OFS_CTRL) begin
            st_next.dat = {31'h0000_0000, st_reg.fifo_en};
        end else if (rd && wb_req_i.adr == uls_pkg::OFS_RX) begin
            st_next.dat = {24'h00_0000, st_reg.rx_mem[st_reg.rx_rd].data};
        end else if (rd && wb_req_i.adr == uls_pkg::OFS_IST) begin
            st_next.dat = {30'h0000_0000, st_reg.irq_st};
        end else if (rd && wb_req_i.adr == uls_pkg::OFS_IMSK) begin
            st_next.dat = {30'h0000_0000, st_reg.irq_mask};
        end

        // input synchroniser and low-time counter
        st_next.line_meta = serial_input_i;
        st_next.line_sync = st_reg.line_meta;
        if (s) begin
            st_next.low_cnt = 16'h0000;
        end else if (st_reg.low_cnt != FRAME_CLKS) begin
            st_next.low_cnt = st_reg.low_cnt + 16'h0001;
        end

        // receiver
        st_next.bit_cnt = st_reg.bit_cnt + 16'h0001;
        case (st_reg.rx_state)
            uls_pkg::RX_IDLE: begin
                st_next.bit_cnt = 16'h0000;
                if (!s) begin
                    st_next.rx_state = uls_pkg::RX_START;
                end
            end
            uls_pkg::RX_START: begin
                if (st_reg.bit_cnt == MID_END) begin
                    st_next.bit_cnt  = 16'h0000;
                    st_next.bit_idx  = 3'h0;
                    st_next.rx_state = s ? uls_pkg::RX_IDLE : uls_pkg::RX_DATA;
                end
            end
            uls_pkg::RX_DATA: begin
                if (st_reg.bit_cnt == BIT_END) begin
                    st_next.bit_cnt = 16'h0000;
                    st_next.shift   = {s, st_reg.shift[7:1]};
                    st_next.bit_idx = st_reg.bit_idx + 3'h1;
                    if (st_reg.bit_idx == 3'h7) begin
                        st_next.rx_state = uls_pkg::RX_STOP;
                    end
                end
            end
            uls_pkg::RX_STOP: begin
                if (st_reg.bit_cnt == BIT_END) begin
                    st_next.rx_state = uls_pkg::RX_IDLE;
                    if (s) begin
                        rx_push       = 1'b1;
                        push_ent.data = st_reg.shift;
                    end else if (st_reg.shift != 8'h00) begin
                        rx_push       = 1'b1;
                        push_ent.frm  = 1'b1;
                        push_ent.data = st_reg.shift;
                    end else begin
                        st_next.rx_state = uls_pkg::RX_HOLD; // maybe a break
                    end
                end
            end
            uls_pkg::RX_HOLD: begin
                if (s) begin
                    rx_push          = 1'b1;
                    push_ent.frm     = 1'b1;
                    st_next.rx_state = uls_pkg::RX_IDLE;
                end else if (st_reg.low_cnt == FRAME_CLKS) begin
                    rx_push          = 1'b1;
                    push_ent.brk     = 1'b1;
                    st_next.rx_state = uls_pkg::RX_MARK;
                end
            end
            uls_pkg::RX_MARK: begin
                if (s) begin
                    st_next.rx_state = uls_pkg::RX_IDLE;
                end
            end
            default: begin
                st_next.rx_state = uls_pkg::RX_IDLE;
            end
        endcase

        // receive FIFO, depth one in single-byte mode
        rx_lim = st_reg.fifo_en ? RX_LIM : (RAW+1)'(1);
        rx_ok  = rx_push && (st_reg.rx_cnt < rx_lim || rx_pop);
        if (rx_pop) begin
            st_next.rx_rd = st_reg.rx_rd + 1'b1;
        end
        if (rx_ok) begin
            st_next.rx_mem[st_reg.rx_wr] = push_ent;
            st_next.rx_wr = st_reg.rx_wr + 1'b1;
        end
        st_next.rx_cnt = st_reg.rx_cnt + (RAW+1)'(rx_ok) - (RAW+1)'(rx_pop);

        // status follows the entry at the head
        head_load = (rx_pop && (st_reg.rx_cnt > (RAW+1)'(1) || rx_ok)) ||
                    (st_reg.rx_cnt == '0 && rx_ok);
        head_ent  = (rx_pop && st_reg.rx_cnt > (RAW+1)'(1)) ?
                    st_reg.rx_mem[st_reg.rx_rd + 1'b1] : push_ent;
        if (head_load) begin
            st_next.brk = head_ent.brk;
            st_next.frm = head_ent.frm;
            irq_ev[uls_pkg::IRQ_RLS] = head_ent.brk || head_ent.frm;
        end else if (stat_rd) begin
            st_next.brk = 1'b0;
            st_next.frm = 1'b0;
        end

        // transmit holding register or FIFO
        tx_lim  = st_reg.fifo_en ? TX_LIM : (TAW+1)'(1);
        tx_take = tx_take_i && st_reg.tx_cnt != '0;
        tx_ok   = tx_push && (st_reg.tx_cnt < tx_lim || tx_take);
        if (tx_take) begin
            st_next.tx_rd = st_reg.tx_rd + 1'b1;
        end
        if (tx_ok) begin
            st_next.tx_mem[st_reg.tx_wr] = wb_req_i.dat[7:0];
            st_next.tx_wr = st_reg.tx_wr + 1'b1;
        end
        st_next.tx_cnt = st_reg.tx_cnt + (TAW+1)'(tx_ok) - (TAW+1)'(tx_take);
        if (tx_ok) begin
            st_next.hold_empty = 1'b0;
        end else if (st_reg.fifo_en ? st_next.tx_cnt == '0 : tx_take) begin
            st_next.hold_empty = 1'b1;
        end

        // mode change flushes both queues
        if (wr && wb_req_i.adr == uls_pkg::OFS_CTRL && wb_req_i.sel[0]) begin
            st_next.fifo_en = wb_req_i.dat[uls_pkg::CTRL_FIFO];
            if (wb_req_i.dat[uls_pkg::CTRL_FIFO] != st_reg.fifo_en) begin
                st_next.rx_rd  = '0;
                st_next.rx_wr  = '0;
                st_next.rx_cnt = '0;
                st_next.tx_rd  = '0;
                st_next.tx_wr  = '0;
                st_next.tx_cnt = '0;
                st_next.hold_empty = 1'b1;
            end
        end

        // sticky interrupt status, write one to clear, set wins
        irq_ev[uls_pkg::IRQ_HOLD] = st_next.hold_empty && !st_reg.hold_empty;
        if (wr && wb_req_i.adr == uls_pkg::OFS_IST && wb_req_i.sel[0]) begin
            st_next.irq_st = st_reg.irq_st & ~wb_req_i.dat[1:0];
        end
        st_next.irq_st = st_next.irq_st | irq_ev;
        if (wr && wb_req_i.adr == uls_pkg::OFS_IMSK && wb_req_i.sel[0]) begin
            st_next.irq_mask = wb_req_i.dat[1:0];
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg          <= '0;
            st_reg.hold_empty <= uls_pkg::STAT_RESET[uls_pkg::STAT_HOLD_BIT];
            st_reg.fifo_en    <= uls_pkg::CTRL_RESET;
            st_reg.line_meta  <= 1'b1;
            st_reg.line_sync  <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign wb_rsp_o.ack = st_reg.ack;
    assign wb_rsp_o.dat = st_reg.dat;
    assign tx_valid_o   = st_reg.tx_cnt != '0;
    assign tx_data_o    = st_reg.tx_mem[st_reg.tx_rd];
    assign irq_o        = |(st_reg.irq_st & st_reg.irq_mask);

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_hold_write_clr: assert property (tx_ok |=> !st_reg.hold_empty)
        else $error("holding-empty not cleared by write");
    a_hold_move_set: assert property (!st_reg.fifo_en && tx_take && !tx_push
                                      |=> st_reg.hold_empty && !tx_valid_o)
        else $error("holding-empty not set on move to shifter");
    a_hold_fifo_empty: assert property (st_reg.fifo_en && st_reg.tx_cnt == '0
                                        |-> st_reg.hold_empty)
        else $error("holding-empty low with empty transmit FIFO");
    a_hold_irq_set: assert property ($rose(st_reg.hold_empty) |-> st_reg.irq_st[1])
        else $error("holding-empty rise did not set interrupt status");
    a_stat_read_map: assert property (stat_rd |=> wb_rsp_o.ack &&
        wb_rsp_o.dat[uls_pkg::STAT_BRK_BIT] == $past(st_reg.brk) &&
        wb_rsp_o.dat[uls_pkg::STAT_FRM_BIT] == $past(st_reg.frm))
        else $error("status read shows wrong break or framing bit");
    a_brk_read_clr: assert property (stat_rd && !head_load
                                     |=> !st_reg.brk && !st_reg.frm)
        else $error("status read did not clear error flags");
    a_brk_detect: assert property (st_reg.rx_state == uls_pkg::RX_HOLD && !s &&
        st_reg.low_cnt == FRAME_CLKS |-> rx_push && push_ent.brk && push_ent.data == 8'h00)
        else $error("long low level not reported as break");
    a_brk_one_char: assert property (st_reg.rx_state == uls_pkg::RX_MARK |-> !rx_push)
        else $error("second character loaded during break");
    a_mark_wait_high: assert property (st_reg.rx_state == uls_pkg::RX_MARK && !s
                                       |=> st_reg.rx_state == uls_pkg::RX_MARK)
        else $error("receiver left break before line went high");
    a_head_flags: assert property (head_load
                                   |=> st_reg.brk == $past(head_ent.brk) &&
                                   st_reg.frm == $past(head_ent.frm))
        else $error("head entry flags not shown in status");
    a_frame_detect: assert property (st_reg.rx_state == uls_pkg::RX_STOP &&
        st_reg.bit_cnt == BIT_END && !s && st_reg.shift != 8'h00 |-> rx_push && push_ent.frm)
        else $error("low stop bit not flagged as framing error");
    a_rls_irq_set: assert property (head_load && (head_ent.brk || head_ent.frm)
                                    |=> st_reg.irq_st[0])
        else $error("line status event did not set interrupt status");

    c_break_char: cover property (rx_ok && push_ent.brk);
    c_frame_err:  cover property (rx_ok && push_ent.frm && push_ent.data != 8'h00);
    c_hold_irq:   cover property (irq_o && st_reg.irq_st[1]);
    c_fifo_fill:  cover property (st_reg.fifo_en && st_reg.tx_cnt == TX_LIM);

endmodule

//--- test/uls_line_model.sv
`timescale 1ns/1ps
module uls_line_model #(
    parameter int CLKS_PER_BIT = 4
) (
    // clock
    input  wire logic clk_i,
    // serial line towards the receiver
    output logic      serial_o
);
    // line idles high between frames
    initial serial_o = 1'b1;

    // holds the line at one level for whole bit times
    task automatic drive_bits(input logic lvl, input int bits);
        repeat (bits * CLKS_PER_BIT) begin
            @(posedge clk_i);
            serial_o <= lvl;
        end
    endtask

    // one frame: start, 8 data bits lsb first, chosen stop level, idle bit
    task automatic send_char(input logic [7:0] data, input logic stop);
        drive_bits(1'b0, 1);
        for (int i = 0; i < 8; i++) begin
            drive_bits(data[i], 1);
        end
        drive_bits(stop, 1);
        drive_bits(1'b1, 1);
    endtask

    // long low spell, then back to idle before any new start bit
    task automatic send_break(input int bits);
        drive_bits(1'b0, bits);
        drive_bits(1'b1, 2);
    endtask
endmodule

//--- test/uls_top_tb.sv
`timescale 1ns/1ps
module uls_top_tb;
    localparam int CPB = 4;

    // clock, reset and stimulus
    logic                    clk_i = 1'b0;
    logic                    rst_i = 1'b1;
    uls_pkg::uls_wb_req_type wb_req_i = '0;
    uls_pkg::uls_wb_rsp_type wb_rsp_o;
    logic                    serial_line;
    logic                    tx_take_i = 1'b0;
    logic                    tx_valid_o;
    logic [7:0]              tx_data_o;
    logic                    irq_o;
    int                      miscompares = 0;
    int                      checks_done = 0;
    int                      cycles = 0;
    logic [31:0]             rd;

    // 10 MHz clock
    always #50 clk_i = ~clk_i;

    uls_top #(.CLKS_PER_BIT(CPB)) u_dut (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .wb_req_i       (wb_req_i),
        .wb_rsp_o       (wb_rsp_o),
        .serial_input_i (serial_line),
        .tx_take_i      (tx_take_i),
        .tx_valid_o     (tx_valid_o),
        .tx_data_o      (tx_data_o),
        .irq_o          (irq_o)
    );

    uls_line_model #(.CLKS_PER_BIT(CPB)) u_line (
        .clk_i    (clk_i),
        .serial_o (serial_line)
    );

    // compares one value and counts it
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one classic wishbone cycle, held until ack is sampled high at a rising edge
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                            output logic [31:0] rdat);
        @(posedge clk_i);
        wb_req_i <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: wd};
        do begin
            @(posedge clk_i);
        end while (wb_rsp_o.ack !== 1'b1);
        rdat = wb_rsp_o.dat;
        wb_req_i <= '0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
        logic [31:0] dummy;
        wb_cycle(1'b1, adr, wd, dummy);
    endtask

    task automatic rd_chk(input string what, input logic [7:0] adr, input logic [31:0] mask,
                          input logic [31:0] exp);
        wb_cycle(1'b0, adr, 32'h0, rd);
        check(what, rd & mask, exp);
    endtask

    // transmit shifter takes one character
    task automatic take();
        @(posedge clk_i);
        tx_take_i <= 1'b1;
        @(posedge clk_i);
        tx_take_i <= 1'b0;
        @(negedge clk_i);
    endtask

    task automatic t_reset();
        rd_chk("status reset", uls_pkg::OFS_STAT, 32'hFFFFFFFF, 32'h20);
        rd_chk("unmapped", 8'h1C, 32'hFFFFFFFF, 32'h0);
        check("irq reset", {31'h0, irq_o}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_single_tx();
        wr(uls_pkg::OFS_IMSK, 32'h2);
        wr(uls_pkg::OFS_IST, 32'h3);
        wr(uls_pkg::OFS_TX, 32'h5A);
        rd_chk("empty after write", uls_pkg::OFS_STAT, 32'h20, 32'h0);
        check("tx data", {24'h0, tx_data_o}, 32'h5A);
        check("irq idle", {31'h0, irq_o}, 32'h0);
        take();
        rd_chk("empty after move", uls_pkg::OFS_STAT, 32'h20, 32'h20);
        check("irq hold", {31'h0, irq_o}, 32'h1);
        rd_chk("irq status", uls_pkg::OFS_IST, 32'hFFFFFFFF, 32'h2);
        wr(uls_pkg::OFS_IST, 32'h2);
        @(negedge clk_i);
        check("irq cleared", {31'h0, irq_o}, 32'h0);
        wr(uls_pkg::OFS_IMSK, 32'h0);
        $display("test single tx done");
    endtask

    task automatic t_fifo_tx();
        wr(uls_pkg::OFS_CTRL, 32'h1);
        rd_chk("fifo mode", uls_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h1);
        rd_chk("empty fifo", uls_pkg::OFS_STAT, 32'h20, 32'h20);
        wr(uls_pkg::OFS_TX, 32'h11);
        wr(uls_pkg::OFS_TX, 32'h22);
        rd_chk("fifo loaded", uls_pkg::OFS_STAT, 32'h20, 32'h0);
        take();
        check("tx next", {24'h0, tx_data_o}, 32'h22);
        rd_chk("one left", uls_pkg::OFS_STAT, 32'h20, 32'h0);
        take();
        rd_chk("fifo drained", uls_pkg::OFS_STAT, 32'h20, 32'h20);
        check("tx valid", {31'h0, tx_valid_o}, 32'h0);
        $display("test fifo tx done");
    endtask

    task automatic t_frame();
        wr(uls_pkg::OFS_IST, 32'h3);
        wr(uls_pkg::OFS_IMSK, 32'h1);
        u_line.send_char(8'h55, 1'b0);
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        check("irq line status", {31'h0, irq_o}, 32'h1);
        rd_chk("frame set", uls_pkg::OFS_STAT, 32'h18, 32'h08);
        rd_chk("frame read clear", uls_pkg::OFS_STAT, 32'h18, 32'h0);
        rd_chk("frame data", uls_pkg::OFS_RX, 32'hFF, 32'h55);
        wr(uls_pkg::OFS_IST, 32'h1);
        wr(uls_pkg::OFS_IMSK, 32'h0);
        $display("test framing done");
    endtask

    task automatic t_break();
        u_line.send_char(8'h3C, 1'b1);
        u_line.send_break(30);
        u_line.send_char(8'hA5, 1'b1);
        repeat (8) @(posedge clk_i);
        rd_chk("brk hidden", uls_pkg::OFS_STAT, 32'h18, 32'h0);
        rd_chk("first char", uls_pkg::OFS_RX, 32'hFF, 32'h3C);
        rd_chk("brk at head", uls_pkg::OFS_STAT, 32'h18, 32'h10);
        rd_chk("brk char", uls_pkg::OFS_RX, 32'hFF, 32'h00);
        rd_chk("brk clean", uls_pkg::OFS_STAT, 32'h18, 32'h0);
        rd_chk("after brk", uls_pkg::OFS_RX, 32'hFF, 32'hA5);
        $display("test break done");
    endtask

    // verdict and end of run
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            end_sim();
        end
    end

    // main sequence
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_single_tx();
        t_fifo_tx();
        t_frame();
        t_break();
        end_sim();
    end
endmodule
